/* File: psu_cfg.svh */
// Constants of the supply status sequencer: offsets, fields, reset values, timing
`ifndef PSU_CFG_SVH
`define PSU_CFG_SVH

`define CLK_KHZ          40000
`define ACOK_ON1_MS      500
`define ACOK_ON2_MS      100
`define ACOK_OFF_MS      5
`define HOLD_MAIN_MS     7
`define HOLD_STANDBY_MS  15
`define MIN_OFF_MS       2000
`define BLINK_PERIOD_MS  1200
`define SYNC_LAG         3

`define IN_COUNT         17
`define IN_AC            0
`define IN_PON_N         1
`define IN_KILL          2
`define IN_HS_PERMIT     3
`define IN_LIGHT_LOAD    4
`define IN_SB_IN_REG     5
`define IN_MAIN_IN_REG   6
`define IN_MAIN_ABOVE_PG 7
`define IN_OT_SHUTDOWN   8
`define IN_OT_WARNING    9
`define IN_OV_SHUTDOWN   10
`define IN_OC_SHUTDOWN   11
`define IN_FAN_MAJOR     12
`define IN_FAN_MINOR     13
`define IN_SB_SEL        14
`define IN_SHARE         15
`define IN_SB_RUN        16
`define SYNC_RESET       17'h0C00E

`define REG_CTRL         8'h00
`define REG_STATUS       8'h04
`define REG_INPUTS       8'h08
`define CTRL_HS_ALLOW    0
`define CTRL_RESET       1'b0

`define ST_MAINS_GOOD    0
`define ST_MAIN_ON       1
`define ST_STANDBY_ON    2
`define ST_FAULT         3
`define ST_HOT_SPARE     4
`define ST_POWER_GOOD    5
`define ST_ALERT         6
`define ST_LED_AC        7
`define ST_LED_GREEN     8
`define ST_LED_YELLOW    9
`define ST_STATE_LO      12

`endif

/* File: psu_pkg.sv */
// Types of the supply status sequencer
`include "psu_cfg.svh"

package psu_pkg;

  typedef enum logic [1:0] {main_off, main_on, main_holdup, main_rest} main_state_type;

  typedef struct packed {
    logic [`IN_COUNT-1:0] sync1;
    logic [`IN_COUNT-1:0] sync2;
    main_state_type       mstate;
    logic [31:0]          timer;
    logic [31:0]          good_timer;
    logic [31:0]          sb_timer;
    logic                 mains_good;
    logic                 standby_on;
    logic                 cold;
    logic                 fault_latch;
    logic                 hs_mode;
    logic                 hs_pull;
    logic                 ctrl_hs;
    logic                 main_en;
    logic                 pgood;
    logic                 alert;
    logic                 led_ac;
    logic                 led_green;
    logic                 led_yellow;
    logic                 share_en;
    logic                 share_tx;
    logic                 share_rx;
    logic                 wr_pend;
    logic [7:0]           addr;
    logic [31:0]          hrdata;
  } seq_state_type;

  typedef struct packed {
    logic [31:0] count;
    logic        half;
    logic        third;
    logic        two_third;
  } blink_state_type;

endpackage

/* File: psu_seq_props.sv */
// Concurrent checks on the supply status sequencer ports
module psu_seq_props #(
  parameter int unsigned HOLD_MAIN_CYC = 20,
  parameter int unsigned HOLD_SB_CYC   = 40
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ac_in_range,
  input wire logic power_on_request_n,
  input wire logic main_kill_request,
  input wire logic standby_in_reg,
  input wire logic ot_warning,
  input wire logic fan_error_minor,
  input wire logic main_enable,
  input wire logic standby_enable,
  input wire logic mains_good_out,
  input wire logic power_good_out,
  input wire logic alert_out_n_en_n,
  input wire logic share_bus_pin_en_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] low_cnt;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Cycles since the AC-good output last stood high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) low_cnt <= '0;
    else if (mains_good_out) low_cnt <= '0;
    else if (low_cnt != 16'hFFFF) low_cnt <= low_cnt + 16'h1;
  end
  kill_main_off_a: assert property (main_kill_request [*6] |-> !main_enable)
    else $error("main output on while kill held");
  pon_main_off_a: assert property (power_on_request_n [*6] |-> !main_enable)
    else $error("main output on while power-on released");
  share_detach_a: assert property (!main_enable [*3] |-> share_bus_pin_en_n)
    else $error("share pin driven while supply off");
  alert_warn_a: assert property ((ot_warning || fan_error_minor) [*5] |-> !alert_out_n_en_n)
    else $error("alert missing on warning");
  acgood_drop_a: assert property (!ac_in_range [*5] |-> !mains_good_out)
    else $error("AC-good late to fall");
  pgood_needs_a: assert property (!standby_in_reg [*5] |-> !power_good_out)
    else $error("power good without standby regulation");
  main_lead_a: assert property ($fell(main_enable) && !mains_good_out |->
    low_cnt >= HOLD_MAIN_CYC - 2)
    else $error("main fell too soon after AC-good");
  standby_lead_a: assert property ($fell(standby_enable) |-> low_cnt >= HOLD_SB_CYC - 2)
    else $error("standby fell too soon after AC-good");
endmodule

bind psu_status_sequencer psu_seq_props #(
  .HOLD_MAIN_CYC(HOLD_MAIN_CYC),
  .HOLD_SB_CYC(HOLD_SB_CYC)
) props (
  .hclk(hclk), .hresetn(hresetn), .ac_in_range(ac_in_range),
  .power_on_request_n(power_on_request_n), .main_kill_request(main_kill_request),
  .standby_in_reg(standby_in_reg), .ot_warning(ot_warning),
  .fan_error_minor(fan_error_minor), .main_enable(main_enable),
  .standby_enable(standby_enable), .mains_good_out(mains_good_out),
  .power_good_out(power_good_out), .alert_out_n_en_n(alert_out_n_en_n),
  .share_bus_pin_en_n(share_bus_pin_en_n)
);

/* File: psu_status_sequencer.sv */
// Power supply status sequencer: main output control, AC-good, LEDs, alert, AHB-Lite registers
//
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`include "psu_cfg.svh"
// Functional notes
// - AC LED green in range, off otherwise
// - Status LED priority: power-on high first, then hot-standby
// - Regulation, shutdown or major fan faults: solid yellow
// - Overtemp warning 2:1, minor fan 1:1
// - Kill high disables main; standby unaffected
// - Auto turn-on with AC and power-on low
// - Cold start AC-good within 500 ms
// - After dip AC-good within 100 ms
// - AC-good drops within 5 ms of loss
// - AC-good leads main 7 ms, standby 15 ms
// - Main minimum off after dropout, max 2000 ms
// - Alert is open drain, no pull-up
// - Share pin disconnected while supply off
// - Control inputs read high when unconnected
// - Power-on low enables main; high clears faults
// - Alert is OR of shutdowns and warnings; the code also ORs in regulation and major fan faults
// - Power good needs standby and main above threshold
module psu_status_sequencer #(
  parameter int unsigned ACOK_ON1_CYC  = `ACOK_ON1_MS * `CLK_KHZ,
  parameter int unsigned ACOK_ON2_CYC  = `ACOK_ON2_MS * `CLK_KHZ,
  parameter int unsigned HOLD_MAIN_CYC = `HOLD_MAIN_MS * `CLK_KHZ,
  parameter int unsigned HOLD_SB_CYC   = `HOLD_STANDBY_MS * `CLK_KHZ,
  parameter int unsigned MIN_OFF_CYC   = `MIN_OFF_MS * `CLK_KHZ,
  parameter int unsigned BLINK_CYC     = `BLINK_PERIOD_MS * `CLK_KHZ
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        ac_in_range,
  input  wire logic        power_on_request_n,
  input  wire logic        main_kill_request,
  input  wire logic        hot_spare_permit,
  input  wire logic        standby_volt_sel,
  input  wire logic        light_load,
  input  wire logic        standby_in_reg,
  input  wire logic        main_in_reg,
  input  wire logic        main_above_pg,
  input  wire logic        ot_shutdown,
  input  wire logic        ot_warning,
  input  wire logic        ov_shutdown,
  input  wire logic        oc_shutdown,
  input  wire logic        fan_error_major,
  input  wire logic        fan_error_minor,
  input  wire logic        standby_running,
  input  wire logic        share_bus_pin,
  input  wire logic        share_tx,
  output logic             share_bus_pin_out,
  output logic             share_bus_pin_en_n,
  output logic             share_rx,
  output logic             hot_spare_permit_out,
  output logic             hot_spare_permit_en_n,
  output logic             alert_out_n,
  output logic             alert_out_n_en_n,
  output logic             main_enable,
  output logic             standby_enable,
  output logic             standby_level_high,
  output logic             mains_good_out,
  output logic             power_good_out,
  output logic             ac_led_green,
  output logic             status_led_green,
  output logic             status_led_yellow
);

  psu_pkg::seq_state_type s;
  psu_pkg::seq_state_type next_s;

  logic        blink_half;
  logic        blink_third;
  logic        blink_two_third;
  logic        ac_ok;
  logic        pon_n;
  logic        kill;
  logic        shutdown_any;
  logic        yellow_fault;
  logic        run_ok;
  logic        take;
  logic        ctrl_now;
  logic [31:0] on_limit;
  logic [31:0] status_word;

  ratio_blinker #(
    .PERIOD (BLINK_CYC)
  ) u_blink (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .half      (blink_half),
    .third     (blink_third),
    .two_third (blink_two_third)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronised inputs and derived conditions

  assign ac_ok = s.sync2[`IN_AC];
  assign pon_n = s.sync2[`IN_PON_N];
  assign kill  = s.sync2[`IN_KILL];

  assign shutdown_any = s.sync2[`IN_OT_SHUTDOWN] | s.sync2[`IN_OV_SHUTDOWN]
                      | s.sync2[`IN_OC_SHUTDOWN];

  // Any condition that forces the status LED solid yellow
  assign yellow_fault = (s.main_en & ~s.sync2[`IN_MAIN_IN_REG])
                      | (s.standby_on & ~s.sync2[`IN_SB_IN_REG])
                      | shutdown_any | s.fault_latch
                      | s.sync2[`IN_FAN_MAJOR];

  assign run_ok = s.mains_good & ~pon_n & ~kill & ~s.fault_latch
                & s.sync2[`IN_SB_IN_REG] & ~s.hs_mode;

  assign on_limit = (s.cold ? ACOK_ON1_CYC : ACOK_ON2_CYC) - 32'(`SYNC_LAG);

  assign take = hsel & htrans[1] & hready;

  // A write to the control word in its data phase is forwarded to a read behind it
  assign ctrl_now = (s.wr_pend && s.addr == `REG_CTRL) ? hwdata[`CTRL_HS_ALLOW] : s.ctrl_hs;

  always_comb begin
    status_word                 = 32'h00000000;
    status_word[`ST_MAINS_GOOD] = s.mains_good;
    status_word[`ST_MAIN_ON]    = s.main_en;
    status_word[`ST_STANDBY_ON] = s.standby_on;
    status_word[`ST_FAULT]      = s.fault_latch;
    status_word[`ST_HOT_SPARE]  = s.hs_mode;
    status_word[`ST_POWER_GOOD] = s.pgood;
    status_word[`ST_ALERT]      = s.alert;
    status_word[`ST_LED_AC]     = s.led_ac;
    status_word[`ST_LED_GREEN]  = s.led_green;
    status_word[`ST_LED_YELLOW] = s.led_yellow;
    status_word[`ST_STATE_LO +: 2] = s.mstate;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_s = s;

    next_s.sync1 = {standby_running, share_bus_pin, standby_volt_sel,
                    fan_error_minor, fan_error_major, oc_shutdown, ov_shutdown,
                    ot_warning, ot_shutdown, main_above_pg, main_in_reg,
                    standby_in_reg, light_load, hot_spare_permit,
                    main_kill_request, power_on_request_n, ac_in_range};
    next_s.sync2 = s.sync1;

    // AC-good: off at once on loss, on after the cold or dip delay
    if (!ac_ok) begin
      next_s.mains_good = 1'b0;
      next_s.good_timer = 32'h00000000;
    end else if (!s.mains_good) begin
      if (s.good_timer >= on_limit) begin
        next_s.mains_good = 1'b1;
        next_s.cold       = 1'b0;
      end else begin
        next_s.good_timer = s.good_timer + 32'h00000001;
      end
    end

    // Standby rail holds up past AC-good loss, then a later start counts as cold
    if (ac_ok) begin
      next_s.standby_on = 1'b1;
      next_s.sb_timer   = 32'h00000000;
    end else if (s.standby_on) begin
      if (s.sb_timer >= HOLD_SB_CYC - 32'd1) begin
        next_s.standby_on = 1'b0;
        next_s.cold       = 1'b1;
      end else begin
        next_s.sb_timer = s.sb_timer + 32'h00000001;
      end
    end

    // Latched shutdowns clear while power-on is released; a new event wins
    next_s.fault_latch = shutdown_any | (s.fault_latch & ~pon_n);

    next_s.hs_mode = s.ctrl_hs & s.sync2[`IN_HS_PERMIT] & s.sync2[`IN_LIGHT_LOAD]
                   & s.mains_good & ~s.fault_latch & ~shutdown_any;
    next_s.hs_pull = s.fault_latch | shutdown_any;

    unique case (s.mstate)
      psu_pkg::main_off: begin
        if (run_ok) begin
          next_s.mstate = psu_pkg::main_on;
        end
      end
      psu_pkg::main_on: begin
        next_s.timer = 32'h00000000;
        if (kill || pon_n || s.fault_latch || s.hs_mode) begin
          next_s.mstate = psu_pkg::main_off;
        end else if (!s.mains_good) begin
          next_s.mstate = psu_pkg::main_holdup;
        end
      end
      psu_pkg::main_holdup: begin
        if (kill || pon_n || s.fault_latch) begin
          next_s.mstate = psu_pkg::main_off;
        end else if (s.mains_good) begin
          next_s.mstate = psu_pkg::main_on;
        end else if (s.timer >= HOLD_MAIN_CYC - 32'd1) begin
          next_s.mstate = psu_pkg::main_rest;
          next_s.timer  = 32'h00000000;
        end else begin
          next_s.timer = s.timer + 32'h00000001;
        end
      end
      psu_pkg::main_rest: begin
        if (s.timer >= MIN_OFF_CYC - 32'd1) begin
          next_s.mstate = psu_pkg::main_off;
          next_s.timer  = 32'h00000000;
        end else begin
          next_s.timer = s.timer + 32'h00000001;
        end
      end
    endcase

    next_s.main_en = (next_s.mstate == psu_pkg::main_on)
                   || (next_s.mstate == psu_pkg::main_holdup);

    next_s.pgood = s.sync2[`IN_SB_IN_REG] & s.sync2[`IN_MAIN_ABOVE_PG] & s.main_en;

    next_s.alert = shutdown_any | s.fault_latch | yellow_fault
                 | s.sync2[`IN_OT_WARNING] | s.sync2[`IN_FAN_MINOR];

    next_s.led_ac = ac_ok;

    if (pon_n) begin
      next_s.led_yellow = blink_half;
      next_s.led_green  = 1'b0;
    end else if (s.hs_mode) begin
      next_s.led_yellow = blink_third;
      next_s.led_green  = ~blink_third;
    end else if (yellow_fault) begin
      next_s.led_yellow = 1'b1;
      next_s.led_green  = 1'b0;
    end else if (s.sync2[`IN_OT_WARNING]) begin
      next_s.led_yellow = blink_two_third;
      next_s.led_green  = ~blink_two_third;
    end else if (s.sync2[`IN_FAN_MINOR]) begin
      next_s.led_yellow = blink_half;
      next_s.led_green  = ~blink_half;
    end else begin
      next_s.led_yellow = 1'b0;
      next_s.led_green  = s.main_en;
    end

    // Share pin only joins the bus while the supply runs without fault
    next_s.share_en = s.main_en & ~s.fault_latch;
    next_s.share_tx = share_tx;
    next_s.share_rx = s.share_en ? s.sync2[`IN_SHARE] : 1'b1;

    // AHB-Lite slave, zero wait states
    if (s.wr_pend && s.addr == `REG_CTRL) begin
      next_s.ctrl_hs = hwdata[`CTRL_HS_ALLOW];
    end
    next_s.wr_pend = take & hwrite;
    if (take) begin
      next_s.addr = haddr[7:0];
    end
    if (take && !hwrite) begin
      unique case (haddr[7:0])
        `REG_CTRL:   next_s.hrdata = {31'h00000000, ctrl_now};
        `REG_STATUS: next_s.hrdata = status_word;
        `REG_INPUTS: next_s.hrdata = {15'h0000, s.sync2};
        default:     next_s.hrdata = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s         <= '0;
      s.sync1   <= `SYNC_RESET;
      s.sync2   <= `SYNC_RESET;
      s.cold    <= 1'b1;
      s.ctrl_hs <= `CTRL_RESET;
      s.share_rx <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s.hrdata;

  assign main_enable        = s.main_en;
  assign standby_enable     = s.standby_on;
  assign standby_level_high = s.sync2[`IN_SB_SEL];
  assign mains_good_out     = s.mains_good;
  assign power_good_out     = s.pgood;
  assign ac_led_green       = s.led_ac;
  assign status_led_green   = s.led_green;
  assign status_led_yellow  = s.led_yellow;
  assign share_rx           = s.share_rx;

  // Open-drain pins only ever pull low; enable low means driving
  assign alert_out_n           = 1'b0;
  assign alert_out_n_en_n      = ~s.alert;
  assign hot_spare_permit_out  = 1'b0;
  assign hot_spare_permit_en_n = ~s.hs_pull;
  assign share_bus_pin_out     = 1'b0;
  assign share_bus_pin_en_n    = ~(s.share_en & ~s.share_tx);

endmodule

/* File: ratio_blinker.sv */
// Free-running blink period divided into halves and thirds
module ratio_blinker #(
  parameter int unsigned PERIOD = 32'd48000000
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  output logic      half,
  output logic      third,
  output logic      two_third
);

  psu_pkg::blink_state_type s;
  psu_pkg::blink_state_type next_s;

  always_comb begin
    next_s = s;
    if (s.count >= PERIOD - 32'd1) begin
      next_s.count = 32'h00000000;
    end else begin
      next_s.count = s.count + 32'h00000001;
    end
    // One period split into fixed proportions
    next_s.half      = (s.count < (PERIOD / 32'd2));
    next_s.third     = (s.count < (PERIOD / 32'd3));
    next_s.two_third = (s.count < ((PERIOD / 32'd3) * 32'd2));
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign half      = s.half;
  assign third     = s.third;
  assign two_third = s.two_third;

endmodule

/* File: sys_ctrl_model.sv */
// System controller model: open-drain control lines and pulled-up shared wires
module sys_ctrl_model (
  input  wire logic pon_cmd,
  input  wire logic kill_cmd,
  input  wire logic plugged,
  input  wire logic alert_out_n,
  input  wire logic alert_out_n_en_n,
  output logic      power_on_request_n,
  output logic      main_kill_request,
  output logic      alert_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  logic present_n;
  // Presence pin reads low while the supply sits in its slot
  assign present_n = !plugged;
  // Released open-drain lines float to the pull-up level
  assign power_on_request_n = pon_cmd;
  // Kill pin shorted to signal ground while plugged unless kill_cmd is high, pulled high when withdrawn
  assign main_kill_request = present_n || kill_cmd;
  // Alert line has only the system pull-up
  assign alert_wire = alert_out_n_en_n ? 1'b1 : alert_out_n;
endmodule

/* File: tb_top.sv */
// Self-checking bench of the supply status sequencer
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ON1 = 200, ON2 = 50, HM = 20, HS = 40, MOFF = 100, BL = 12;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ac = 0, pon_cmd = 0;
  logic        kill_cmd = 0, plugged = 1, ll = 0, sbreg = 1, ots = 0, otw = 0, ov = 0;
  logic        fmaj = 0, fmin = 0, share_tx = 1, alert_wire, pon_w, kill_w, rdy;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, d, r;
  logic        hresp, sh_out, sh_en_n, hs_out, hs_en_n, al_out, al_en_n, main_enable;
  logic        standby_enable, mains_good_out, power_good_out, ac_led, led_g, led_y;
  logic [4:0]  tbl [6] = '{5'h08, 5'h04, 5'h0C, 5'h02, 5'h01, 5'h10};
  int          miscompares = 0, n_checks = 0, n, c, t, tg, rd;
  sys_ctrl_model partner (.pon_cmd(pon_cmd), .kill_cmd(kill_cmd), .plugged(plugged),
    .alert_out_n(al_out), .alert_out_n_en_n(al_en_n), .power_on_request_n(pon_w),
    .main_kill_request(kill_w), .alert_wire(alert_wire));
  psu_status_sequencer #(.ACOK_ON1_CYC(ON1), .ACOK_ON2_CYC(ON2), .HOLD_MAIN_CYC(HM),
    .HOLD_SB_CYC(HS), .MIN_OFF_CYC(MOFF), .BLINK_CYC(BL)) dut (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(rdy), .hreadyout(rdy), .hresp(hresp),
    .hrdata(hrdata), .ac_in_range(ac), .power_on_request_n(pon_w),
    .main_kill_request(kill_w), .hot_spare_permit(hs_en_n), .standby_volt_sel(1'b1),
    .light_load(ll), .standby_in_reg(sbreg), .main_in_reg(1'b1), .main_above_pg(1'b1),
    .ot_shutdown(ots), .ot_warning(otw), .ov_shutdown(ov), .oc_shutdown(1'b0),
    .fan_error_major(fmaj), .fan_error_minor(fmin), .standby_running(1'b1),
    .share_bus_pin(sh_en_n), .share_tx(share_tx), .share_bus_pin_out(sh_out),
    .share_bus_pin_en_n(sh_en_n), .share_rx(), .hot_spare_permit_out(hs_out),
    .hot_spare_permit_en_n(hs_en_n), .alert_out_n(al_out), .alert_out_n_en_n(al_en_n),
    .main_enable(main_enable), .standby_enable(standby_enable),
    .standby_level_high(), .mains_good_out(mains_good_out),
    .power_good_out(power_good_out), .ac_led_green(ac_led), .status_led_green(led_g),
    .status_led_yellow(led_y));
  initial begin
    forever #12.5 hclk = ~hclk;
  end
  always @(posedge hclk) share_tx <= 1'($urandom);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [32:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, wd, output logic [31:0] rdat);
    @(posedge hclk);
    hsel <= 1; haddr <= a; htrans <= 2'h2; hwrite <= w;
    do @(posedge hclk); while (rdy !== 1'b1);
    hsel <= 0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge hclk); while (rdy !== 1'b1);
    rdat = hrdata;
  endtask
  task automatic wt(ref logic s, input logic v, input int lim, output int k);
    k = 0;
    while (s !== v && k < lim) begin
      @(negedge hclk);
      k++;
    end
  endtask
  task automatic cnt(output int k);
    k = 0;
    repeat (8) @(negedge hclk);
    repeat (BL) begin
      @(negedge hclk);
      k += int'(led_y === 1'b1);
    end
  endtask
  // Reference pattern: yellow cycles per blink period, highest priority first
  function automatic int exp_yel(logic [4:0] s, logic hs);
    if (s[4]) return BL / 2;
    if (hs) return BL / 3;
    if (s[1] || s[0]) return BL;
    if (s[3]) return 2 * BL / 3;
    if (s[2]) return BL / 2;
    return 0;
  endfunction
  task end_sim;
    if (miscompares == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #(25 * 8000);
    miscompares++;
    end_sim;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(73));
    repeat (8) @(posedge hclk);
    hresetn <= 1;
    @(negedge hclk);
    chk({main_enable, mains_good_out, al_en_n}, 3'b001);
    r = $urandom;
    ahb(1, 32'h0, r, d);
    ahb(0, 32'h0, 32'h0, d);
    chk(d, r & 32'h1);
    ahb(0, 32'h10, 32'h0, d);
    chk(d, 32'h0);
    ahb(1, 32'h0, 32'h0, d);
    ahb(0, 32'h8, 32'h0, d);
    chk(d, {15'h0, 3'h7, fmin, fmaj, 1'b0, ov, otw, ots, 2'h3, sbreg, ll, 1'b1, 2'h0, ac});
    @(posedge hclk) ac <= 1;
    wt(mains_good_out, 1, ON1 + 20, n);
    chk(n <= ON1 + 8, 1);
    wt(main_enable, 1, 10, n);
    @(negedge hclk);
    chk({main_enable, ac_led, power_good_out, led_g}, 4'hF);
    ahb(0, 32'h4, 32'h0, d);
    chk(d & 32'h3007, 32'h1007);
    foreach (tbl[i]) begin
      @(posedge hclk) {pon_cmd, otw, fmin, fmaj, ots} <= tbl[i];
      cnt(c);
      chk(c, exp_yel(tbl[i], 0));
      if (tbl[i][3]) chk(alert_wire, 0);
    end
    @(posedge hclk) {pon_cmd, otw, fmin, fmaj, ots} <= 0;
    ahb(1, 32'h0, 32'h1, d);
    @(posedge hclk) ll <= 1;
    cnt(c);
    chk({c, main_enable}, {exp_yel(0, 1), 1'b0});
    @(posedge hclk) pon_cmd <= 1;
    cnt(c);
    chk(c, exp_yel(5'h10, 1));
    @(posedge hclk) {pon_cmd, ll} <= 0;
    ahb(1, 32'h0, 32'h0, d);
    wt(main_enable, 1, 40, n);
    @(posedge hclk) ov <= 1;
    repeat (5) @(posedge hclk);
    ov <= 0;
    cnt(c);
    chk({c, main_enable}, {BL, 1'b0});
    @(posedge hclk) pon_cmd <= 1;
    repeat (10) @(posedge hclk);
    pon_cmd <= 0;
    wt(main_enable, 1, 40, n);
    cnt(c);
    chk({c, main_enable}, {32'd0, 1'b1});
    @(posedge hclk) {kill_cmd, sbreg} <= 2'b10;
    wt(main_enable, 0, 10, n);
    repeat (6) @(negedge hclk);
    chk({main_enable, standby_enable, power_good_out}, 3'b010);
    @(posedge hclk) {kill_cmd, plugged, sbreg} <= 3'b001;
    repeat (10) @(negedge hclk);
    chk(main_enable, 0);
    @(posedge hclk) {plugged, sbreg} <= 2'b11;
    wt(main_enable, 1, 40, n);
    @(posedge hclk) ac <= 0;
    wt(mains_good_out, 0, 20, n);
    chk(n <= 5, 1);
    wt(main_enable, 0, HM + 20, n);
    chk({standby_enable, ac_led}, 2'b10);
    rd = $urandom_range(5, 1);
    repeat (rd) @(posedge hclk);
    ac <= 1;
    t = 0;
    tg = 999;
    while (main_enable !== 1'b1 && t < MOFF + ON2 + 40) begin
      @(negedge hclk);
      t++;
      if (tg == 999 && mains_good_out === 1'b1) tg = t;
    end
    chk({tg <= ON2 + 8, rd + t <= MOFF + 10}, 2'b11);
    @(posedge hclk) ac <= 0;
    wt(standby_enable, 0, HS + 30, n);
    chk({standby_enable, main_enable, mains_good_out}, 3'b000);
    end_sim;
  end
endmodule
